// ==== src/sbc_pkg.sv ====
// shared constants for the serial control port
package sbc_pkg;
  // --------------------------------------------------------------
  // frame layout
  // --------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int IN_WD_BIT = 15;
  localparam int IN_MODE_HI = 14;
  localparam int IN_MODE_LO = 12;
  localparam int IN_SEL_HI = 11;
  localparam int IN_SEL_LO = 9;
  localparam int IN_DATA_HI = 7;
  localparam int OUT_FRAME_ERR_BIT = 15;
  localparam int OUT_WAKE_BIT = 14;
  localparam int OUT_MODE_HI = 13;
  localparam int OUT_MODE_LO = 11;
  localparam int OUT_CMD_ERR_BIT = 10;
  // mid-frame positions: 7 bits received when the read-back is loaded
  localparam int RX_MODE_HI = 5;
  localparam int RX_MODE_LO = 3;
  localparam int RX_SEL_HI = 2;
  localparam logic [3:0] RO_LOAD_EDGE = 4'h7;
  localparam logic [3:0] COUNT_ONE = 4'h1;
  localparam logic [3:0] COUNT_MATCH = 4'h0;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_REGS = 8;
  // --------------------------------------------------------------
  // mode selection codes
  // --------------------------------------------------------------
  localparam logic [2:0] MS_INVALID = 3'h0;
  localparam logic [2:0] MS_RESTART = 3'h1;
  localparam logic [2:0] MS_SWFLASH = 3'h2;
  localparam logic [2:0] MS_NORMAL = 3'h3;
  localparam logic [2:0] MS_SLEEP = 3'h4;
  localparam logic [2:0] MS_STOP = 3'h5;
  localparam logic [2:0] MS_FAILSAFE = 3'h6;
  localparam logic [2:0] MS_READONLY = 3'h7;
  typedef enum logic [6:0] {
    ST_INIT = 7'h01,
    ST_RESTART = 7'h02,
    ST_SWFLASH = 7'h04,
    ST_NORMAL = 7'h08,
    ST_SLEEP = 7'h10,
    ST_STOP = 7'h20,
    ST_FAILSAFE = 7'h40
  } sbc_mode_t;
endpackage

// ==== src/sbc_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ns
module sbc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== src/sbc_spi_control_port.sv ====
// serial control port: link shifter, frame check, mode control
`timescale 1ns/1ns
module sbc_spi_control_port
  import sbc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CHIP_SELECT_LOW,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  input wire logic WAKE_INPUT_PIN,
  input wire logic SW_DEV_MODE,
  input wire logic CMD_ERR_INHIBIT,
  input wire logic CMD_ERR_CLEAR,
  output logic [15:0] CONTROL_WORD,
  output logic CONTROL_VALID,
  output logic WATCHDOG_TRIGGER_BIT,
  output logic [2:0] CURRENT_MODE,
  output logic CMD_ERROR,
  output logic FRAME_ERROR_FLAG,
  output logic INT_REQ
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // link side (serial clock domain)
  // ----------------------------------------------------------------
  logic arm_set;
  logic rx_armed;
  logic tx_armed;
  logic [15:0] rx_shift;
  logic [3:0] rx_count;
  logic frame_tog;
  logic [15:0] tx_shift;
  logic [3:0] tx_count;
  logic [15:0] out_word;
  logic [7:0] cfg_reg [0:CFG_REGS-1];

  // select high rearms both shifters; its edges carry no clock
  assign arm_set = CHIP_SELECT_LOW | ~rst_sync;

  always_ff @(negedge SCLK or posedge arm_set) begin
    if (arm_set) begin
      rx_armed <= 1'b1;
    end else begin
      rx_armed <= 1'b0;
    end
  end

  always_ff @(posedge SCLK or posedge arm_set) begin
    if (arm_set) begin
      tx_armed <= 1'b1;
    end else begin
      tx_armed <= 1'b0;
    end
  end

  always_ff @(negedge SCLK or negedge rst_sync) begin
    if (!rst_sync) begin
      rx_shift <= WORD_RESET;
      rx_count <= COUNT_MATCH;
      frame_tog <= 1'b0;
    end else if (!CHIP_SELECT_LOW) begin
      rx_shift <= {rx_shift[FRAME_BITS-2:0], SDI};
      if (rx_armed) begin
        rx_count <= COUNT_ONE;
        frame_tog <= ~frame_tog;
      end else begin
        rx_count <= rx_count + COUNT_ONE;
      end
    end
  end

  // read-back register is static during a frame: written only after select rises
  always_ff @(posedge SCLK or negedge rst_sync) begin
    if (!rst_sync) begin
      tx_shift <= WORD_RESET;
      tx_count <= COUNT_MATCH;
    end else if (!CHIP_SELECT_LOW) begin
      if (tx_armed) begin
        tx_shift <= {out_word[FRAME_BITS-2:0], 1'b0};
        tx_count <= COUNT_ONE;
      end else if (tx_count == RO_LOAD_EDGE && rx_shift[RX_MODE_HI:RX_MODE_LO] == MS_READONLY) begin
        tx_shift <= {cfg_reg[rx_shift[RX_SEL_HI:0]], 8'h00};
        tx_count <= tx_count + COUNT_ONE;
      end else begin
        tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
        tx_count <= tx_count + COUNT_ONE;
      end
    end
  end

  // first bit must stand before any rising edge, so it bypasses the shifter
  assign SDO = tx_armed ? out_word[OUT_FRAME_ERR_BIT] : tx_shift[FRAME_BITS-1];
  assign SDO_OE = ~CHIP_SELECT_LOW;

  // ----------------------------------------------------------------
  // crossings into the core clock
  // ----------------------------------------------------------------
  logic cs_sync;
  logic cs_prev;
  logic [1:0] pins_sync;
  logic wake_level;
  logic sw_dev;
  logic frame_end;

  sbc_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_cs_sync (
    .clk(CLK),
    .rst_n(rst_sync),
    .d(CHIP_SELECT_LOW),
    .q(cs_sync)
  );

  sbc_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_pin_sync (
    .clk(CLK),
    .rst_n(rst_sync),
    .d({WAKE_INPUT_PIN, SW_DEV_MODE}),
    .q(pins_sync)
  );

  assign wake_level = pins_sync[1];
  assign sw_dev = pins_sync[0];

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_sync;
    end
  end

  assign frame_end = cs_sync & ~cs_prev;

  // ----------------------------------------------------------------
  // frame evaluation
  // ----------------------------------------------------------------
  sbc_mode_t mode_state;
  logic seen_tog;
  logic count_ok;
  logic cmd_legal;
  logic frame_good;
  logic corrupted;
  logic [2:0] mode_req;
  logic [2:0] last_sel;
  logic hold;

  function automatic logic is_legal(input logic [2:0] req, input sbc_mode_t st, input logic dev);
    logic ok;
    ok = 1'b0;
    // failsafe has no way out short of a reset; sleep leaves only for failsafe, when dev is set
    unique case (req)
      MS_INVALID: ok = 1'b0;
      MS_RESTART: ok = (st == ST_SWFLASH);
      MS_SWFLASH: ok = (st == ST_NORMAL);
      MS_NORMAL: ok = (st != ST_SLEEP) && (st != ST_FAILSAFE);
      MS_SLEEP: ok = (st == ST_NORMAL);
      MS_STOP: ok = (st == ST_NORMAL);
      MS_FAILSAFE: ok = dev;
      MS_READONLY: ok = 1'b1;
    endcase
    return ok;
  endfunction

  function automatic sbc_mode_t target(input logic [2:0] req, input sbc_mode_t st);
    sbc_mode_t t;
    t = st;
    unique case (req)
      MS_RESTART: t = ST_RESTART;
      MS_SWFLASH: t = ST_SWFLASH;
      MS_NORMAL: t = ST_NORMAL;
      MS_SLEEP: t = ST_SLEEP;
      MS_STOP: t = ST_STOP;
      MS_FAILSAFE: t = ST_FAILSAFE;
      MS_INVALID, MS_READONLY: t = st;
    endcase
    return t;
  endfunction

  function automatic logic [2:0] mode_code(input sbc_mode_t st);
    logic [2:0] c;
    c = MS_INVALID;
    unique case (st)
      ST_INIT: c = MS_INVALID;
      ST_RESTART: c = MS_RESTART;
      ST_SWFLASH: c = MS_SWFLASH;
      ST_NORMAL: c = MS_NORMAL;
      ST_SLEEP: c = MS_SLEEP;
      ST_STOP: c = MS_STOP;
      ST_FAILSAFE: c = MS_FAILSAFE;
      default: c = MS_INVALID;
    endcase
    return c;
  endfunction

  // link registers are read only after select rose and the clock stopped
  assign mode_req = rx_shift[IN_MODE_HI:IN_MODE_LO];
  assign count_ok = (frame_tog != seen_tog) && (rx_count == COUNT_MATCH);
  assign cmd_legal = is_legal(mode_req, mode_state, sw_dev);
  assign frame_good = frame_end & count_ok & cmd_legal;
  assign corrupted = frame_end & ~(count_ok & cmd_legal);

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      seen_tog <= 1'b0;
    end else if (frame_end) begin
      seen_tog <= frame_tog;
    end
  end

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      mode_state <= ST_INIT;
    end else if (frame_good) begin
      mode_state <= target(mode_req, mode_state);
    end
  end

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      for (int i = 0; i < CFG_REGS; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
      last_sel <= 3'h0;
    end else if (frame_good) begin
      last_sel <= rx_shift[IN_SEL_HI:IN_SEL_LO];
      if (mode_req != MS_READONLY) begin
        cfg_reg[rx_shift[IN_SEL_HI:IN_SEL_LO]] <= rx_shift[IN_DATA_HI:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      CONTROL_WORD <= WORD_RESET;
      CONTROL_VALID <= 1'b0;
      WATCHDOG_TRIGGER_BIT <= 1'b0;
    end else begin
      CONTROL_VALID <= frame_good && (mode_req != MS_READONLY);
      if (frame_good) begin
        WATCHDOG_TRIGGER_BIT <= rx_shift[IN_WD_BIT];
        if (mode_req != MS_READONLY) begin
          CONTROL_WORD <= rx_shift;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // error flags and status word
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      CMD_ERROR <= 1'b0;
    end else if (corrupted) begin
      CMD_ERROR <= 1'b1;
    end else if (CMD_ERR_CLEAR) begin
      CMD_ERROR <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      INT_REQ <= 1'b0;
    end else begin
      INT_REQ <= CMD_ERROR & ~CMD_ERR_INHIBIT;
    end
  end

  // flag stays up for the one frame that reports it
  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      FRAME_ERROR_FLAG <= 1'b0;
    end else if (frame_end) begin
      FRAME_ERROR_FLAG <= ~count_ok;
    end
  end

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      hold <= 1'b0;
    end else if (frame_end) begin
      hold <= corrupted;
    end
  end

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      CURRENT_MODE <= MS_INVALID;
    end else begin
      CURRENT_MODE <= mode_code(mode_state);
    end
  end

  // frozen while a frame may be reading it
  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      out_word <= WORD_RESET;
    end else if (cs_sync && cs_prev) begin
      if (hold) begin
        out_word[OUT_FRAME_ERR_BIT] <= FRAME_ERROR_FLAG;
      end else begin
        out_word <= {FRAME_ERROR_FLAG, wake_level, mode_code(mode_state), CMD_ERROR, 2'b00,
                     cfg_reg[last_sel]};
      end
    end
  end
endmodule

// ==== verification/sbc_checker.sv ====
// concurrent checks on the serial control port
`timescale 1ns/1ns
module sbc_checker
  import sbc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CHIP_SELECT_LOW,
  input wire logic SDO,
  input wire logic SDO_OE,
  input wire logic CMD_ERR_INHIBIT,
  input wire logic CMD_ERR_CLEAR,
  input wire logic [15:0] CONTROL_WORD,
  input wire logic CONTROL_VALID,
  input wire logic CMD_ERROR,
  input wire logic FRAME_ERROR_FLAG,
  input wire logic INT_REQ
);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_oe_select: assert property (SDO_OE == !CHIP_SELECT_LOW)
    else $error("output enable not following select");
  chk_valid_pulse: assert property (CONTROL_VALID |=> !CONTROL_VALID)
    else $error("valid longer than one cycle");
  chk_word_hold: assert property (!CONTROL_VALID |-> $stable(CONTROL_WORD))
    else $error("control word moved without valid");
  chk_int_follow: assert property (1'b1 |=> INT_REQ == $past(CMD_ERROR && !CMD_ERR_INHIBIT))
    else $error("interrupt not following error");
  chk_err_sticky: assert property (CMD_ERROR && !CMD_ERR_CLEAR |=> CMD_ERROR)
    else $error("error flag dropped");
  chk_mode_legal: assert property (CONTROL_VALID |-> CONTROL_WORD[14:12] != MS_INVALID)
    else $error("zero mode accepted");
  chk_ro_nowrite: assert property (CONTROL_VALID |-> CONTROL_WORD[14:12] != MS_READONLY)
    else $error("read-only frame written");
  chk_select_high: assert property (CONTROL_VALID |-> $past(CHIP_SELECT_LOW))
    else $error("word applied while selected");
  chk_ferr_valid: assert property (CONTROL_VALID |-> !FRAME_ERROR_FLAG)
    else $error("bad frame applied");
  chk_sdo_ferr: assert property ($fell(CHIP_SELECT_LOW) |-> SDO == FRAME_ERROR_FLAG)
    else $error("first output bit not frame error");
  cover property (CONTROL_VALID);
  cover property ($rose(CMD_ERROR));
  cover property ($rose(FRAME_ERROR_FLAG));
endmodule

bind sbc_spi_control_port sbc_checker sbc_checker_inst (.CLK, .RST_N, .CHIP_SELECT_LOW, .SDO, .SDO_OE,
  .CMD_ERR_INHIBIT, .CMD_ERR_CLEAR, .CONTROL_WORD, .CONTROL_VALID, .CMD_ERROR, .FRAME_ERROR_FLAG, .INT_REQ);

// ==== verification/sbc_host_model.sv ====
// host microcontroller acting as serial master
`timescale 1ns/1ns
module sbc_host_model (
  output logic sclk,
  output logic cs_low,
  output logic sdi,
  input wire logic sdo
);
  // ------------------------------------------------
  // frame driver, link clock 30 ns, still between frames
  // ------------------------------------------------
  initial begin
    sclk = 1'b0;
    cs_low = 1'b1;
    sdi = 1'b0;
  end
  // data moves just after the rising edge, so the sampling fall never races it
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    int i;
    r = 16'h0000;
    cs_low = 1'b0;
    #150;
    r[15] = sdo;
    for (i = 0; i < n; i++) begin
      #15 sclk = 1'b1;
      sdi = w[15 - (i % 16)];
      #15 sclk = 1'b0;
      if (i < 15) begin
        r[14 - i] = sdo;
      end
    end
    #15 cs_low = 1'b1;
    sdi = ~sdi; // line inverted, last bit not left standing
    #400;
  endtask
endmodule

// ==== verification/test_sbc_spi_control_port.sv ====
// testbench for the serial control port
`timescale 1ns/1ns
module test_sbc_spi_control_port;
  import sbc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_low, sdi, sdo, sdo_oe, wd, cvalid, cerr, ferr, irq;
  logic wake = 1'b1;
  logic dev = 1'b0;
  logic inh = 1'b0;
  logic clr = 1'b0;
  logic [15:0] cword, rx, prev;
  logic [2:0] mode;
  int miscompares = 0;
  int check_count = 0;
  always #20 clk = ~clk;
  sbc_spi_control_port sbc_spi_control_port_inst (.CLK(clk), .RST_N(rst_n), .SCLK(sclk),
    .CHIP_SELECT_LOW(cs_low), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .WAKE_INPUT_PIN(wake),
    .SW_DEV_MODE(dev), .CMD_ERR_INHIBIT(inh), .CMD_ERR_CLEAR(clr), .CONTROL_WORD(cword),
    .CONTROL_VALID(cvalid), .WATCHDOG_TRIGGER_BIT(wd), .CURRENT_MODE(mode), .CMD_ERROR(cerr),
    .FRAME_ERROR_FLAG(ferr), .INT_REQ(irq));
  sbc_host_model sbc_host_model_inst (.sclk(sclk), .cs_low(cs_low), .sdi(sdi), .sdo(sdo));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic send(input logic [2:0] ms, input logic w, input logic [7:0] d, input int n);
    sbc_host_model_inst.xfer({w, ms, 3'h4, 1'b0, d}, n, rx);
  endtask
  task automatic clear_err();
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (3) @(posedge clk);
    chk_bit("cleared", 1'b0, cerr);
    chk_bit("irq off", 1'b0, irq);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_normal();
    send(MS_NORMAL, 1'b1, 8'h5a, 16);
    chk_word("word", {1'b1, MS_NORMAL, 3'h4, 1'b0, 8'h5a}, cword);
    chk_word("mode", {13'h0000, MS_NORMAL}, {13'h0000, mode});
    chk_bit("wd", 1'b1, wd);
    $display("t_normal done");
  endtask
  task automatic t_readonly();
    sbc_host_model_inst.xfer({1'b0, MS_READONLY, 3'h5, 1'b0, 8'h00}, 16, rx);
    chk_word("ro data", {8'h00, CFG_RESET}, {8'h00, rx[7:0]});
    chk_bit("wake bit", 1'b1, rx[14]);
    chk_word("out mode", {13'h0000, MS_NORMAL}, {13'h0000, rx[13:11]});
    chk_word("ro word", {1'b1, MS_NORMAL, 3'h4, 1'b0, 8'h5a}, cword);
    chk_bit("ro wd", 1'b0, wd);
    $display("t_readonly done");
  endtask
  task automatic t_short();
    send(MS_NORMAL, 1'b1, 8'h33, 15);
    prev = rx;
    chk_bit("frame err", 1'b1, ferr);
    chk_bit("cmd err", 1'b1, cerr);
    chk_bit("irq", 1'b1, irq);
    chk_word("kept", {1'b1, MS_NORMAL, 3'h4, 1'b0, 8'h5a}, cword);
    send(MS_NORMAL, 1'b1, 8'h33, 16);
    chk_bit("sdo frame err", 1'b1, rx[15]);
    chk_word("repeat", {1'b0, prev[14:0]}, {1'b0, rx[14:0]});
    chk_word("applied", {1'b1, MS_NORMAL, 3'h4, 1'b0, 8'h33}, cword);
    chk_bit("err gone", 1'b0, ferr);
    clear_err();
    $display("t_short done");
  endtask
  task automatic t_bad_mode();
    @(posedge clk) inh <= 1'b1;
    send(MS_INVALID, 1'b0, 8'h77, 16);
    chk_bit("zero mode err", 1'b1, cerr);
    chk_bit("masked irq", 1'b0, irq);
    chk_word("zero kept", {1'b1, MS_NORMAL, 3'h4, 1'b0, 8'h33}, cword);
    @(posedge clk) inh <= 1'b0;
    clear_err();
    $display("t_bad_mode done");
  endtask
  task automatic t_illegal();
    send(MS_STOP, 1'b0, 8'h11, 16);
    chk_word("stop", {13'h0000, MS_STOP}, {13'h0000, mode});
    send(MS_SWFLASH, 1'b1, 8'h22, 16);
    chk_bit("illegal err", 1'b1, cerr);
    chk_word("stay stop", {13'h0000, MS_STOP}, {13'h0000, mode});
    clear_err();
    send(MS_NORMAL, 1'b1, 8'h44, 32);
    chk_word("32 edges", {1'b1, MS_NORMAL, 3'h4, 1'b0, 8'h44}, cword);
    $display("t_illegal done");
  endtask
  task automatic t_mode_walk();
    send(MS_SWFLASH, 1'b0, 8'h66, 16);
    chk_word("swflash", {13'h0000, MS_SWFLASH}, {13'h0000, mode});
    send(MS_RESTART, 1'b1, 8'h67, 16);
    chk_word("restart", {13'h0000, MS_RESTART}, {13'h0000, mode});
    send(MS_NORMAL, 1'b0, 8'h68, 16);
    chk_word("back normal", {13'h0000, MS_NORMAL}, {13'h0000, mode});
    chk_word("walk word", {1'b0, MS_NORMAL, 3'h4, 1'b0, 8'h68}, cword);
    $display("t_mode_walk done");
  endtask
  task automatic t_wake_failsafe();
    @(posedge clk) wake <= 1'b0;
    repeat (4) @(posedge clk);
    send(MS_FAILSAFE, 1'b1, 8'h00, 16);
    chk_bit("wake low", 1'b0, rx[14]);
    chk_bit("no dev err", 1'b1, cerr);
    chk_word("no failsafe", {13'h0000, MS_NORMAL}, {13'h0000, mode});
    clear_err();
    @(posedge clk) dev <= 1'b1;
    repeat (4) @(posedge clk);
    send(MS_FAILSAFE, 1'b1, 8'h00, 16);
    chk_word("failsafe", {13'h0000, MS_FAILSAFE}, {13'h0000, mode});
    send(MS_NORMAL, 1'b0, 8'h69, 16);
    chk_bit("locked err", 1'b1, cerr);
    chk_word("stay failsafe", {13'h0000, MS_FAILSAFE}, {13'h0000, mode});
    clear_err();
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) dev <= 1'b0;
    $display("t_wake_failsafe done");
  endtask
  task automatic t_reset_sleep();
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_word("reset word", WORD_RESET, cword);
    chk_word("reset mode", {13'h0000, MS_INVALID}, {13'h0000, mode});
    send(MS_NORMAL, 1'b1, 8'h70, 16);
    send(MS_SLEEP, 1'b0, 8'h71, 16);
    chk_word("sleep", {13'h0000, MS_SLEEP}, {13'h0000, mode});
    send(MS_NORMAL, 1'b1, 8'h72, 16);
    chk_bit("sleep locked", 1'b1, cerr);
    chk_word("sleep word", {1'b0, MS_SLEEP, 3'h4, 1'b0, 8'h71}, cword);
    clear_err();
    $display("t_reset_sleep done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_normal();
    t_readonly();
    t_short();
    t_bad_mode();
    t_illegal();
    t_mode_walk();
    t_wake_failsafe();
    t_reset_sleep();
    close_out();
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
